// ### pkg/pmbus_slave_pkg.sv
`default_nettype none
package pmbus_slave_pkg;

  // command codes of the registers this engine holds itself
  localparam logic [7:0] CMD_INTERFACE_CONFIG_ONE = 8'hD1;
  localparam logic [7:0] CMD_WRITE_LOCK_AND_RESET = 8'hDA;

  // field positions
  localparam int IDLE_RELEASE_ENABLE_BIT = 3;
  localparam int LOCK_SET_BIT = 0;

  // reset values
  localparam logic [7:0] INTERFACE_CONFIG_ONE_RESET = 8'h00;
  localparam logic LOCK_FLAG_RESET = 1'b0;

  // command range guarded by the lock flag
  localparam logic [7:0] PROTECTED_CMD_LOW = 8'hD0;
  localparam logic [7:0] PROTECTED_CMD_HIGH = 8'hDF;

  // slave address, value arbitrary
  localparam logic [6:0] SLAVE_ADDRESS_DEFAULT = 7'h20;

  // timing
  localparam int CORE_CLK_KHZ = 250000;
  localparam int IDLE_RELEASE_MS = 35;
  localparam int IDLE_RELEASE_CYCLES = IDLE_RELEASE_MS * CORE_CLK_KHZ;
  localparam int IDLE_COUNT_WIDTH = 24;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_RX_ACK = 3'b100,
    ST_TX = 3'b101,
    ST_TX_ACK = 3'b110
  } slave_state_type;

endpackage
`default_nettype wire

// ### rtl/pmbus_bit_sampler.sv
`timescale 1ns/10ps
`default_nettype none

// runs on the bus clock; one data bit caught per rising edge.
// the caught bit stays put until the next rising edge, which is many
// core cycles away, so the core reads it once the toggle has crossed.
module pmbus_bit_sampler
(
  // clock and reset
  input wire logic scl_clk,
  input wire logic reset,
  // bus data pin
  input wire logic sda_in,
  // towards the core domain
  output logic sampled_bit,
  output logic bit_toggle
);

  logic next_sampled_bit;
  logic next_bit_toggle;

  always_comb
  begin
    next_sampled_bit = sda_in;
    next_bit_toggle = ~bit_toggle;
  end

  always_ff @(posedge scl_clk or posedge reset)
  begin
    if (reset)
    begin
      sampled_bit <= 1'b1;
      bit_toggle <= 1'b0;
    end
    else
    begin
      sampled_bit <= next_sampled_bit;
      bit_toggle <= next_bit_toggle;
    end
  end

endmodule
`default_nettype wire

// ### rtl/pmbus_slave_protocol_engine.sv
// Summary of operation
// R1: write word: address, command, two bytes, all acked
// R2: block write: command, count N, N bytes
// R3: ack address, command, count and block bytes
// R4: read byte: command, repeated start, one byte
// R5: read word returns low byte then high byte
// R6: block read returns count then N bytes
// R7: idle timeout releases the bus when enabled
// R8: config bit 3 enables timeout, default off
// R9: writing bit 0 sets sticky lock flag
// R10: locked registers ignore writes until power cycle
// R11: command code written before every read
// R12: send byte clears recorded faults
// R13: after timeout return idle, await fresh start
`timescale 1ns/10ps
`default_nettype none

module pmbus_slave_protocol_engine
#(
  parameter logic [6:0] SLAVE_ADDRESS = pmbus_slave_pkg::SLAVE_ADDRESS_DEFAULT,
  parameter int IDLE_RELEASE_LIMIT = pmbus_slave_pkg::IDLE_RELEASE_CYCLES
)
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bus clock: as a clock and as a level
  input wire logic scl_clk,
  input wire logic scl_in,
  // bus data, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // register writes towards the device
  output logic wr_strobe,
  output logic [7:0] wr_cmd,
  output logic [7:0] wr_index,
  output logic [7:0] wr_byte,
  // register reads from the device
  output logic [7:0] rd_cmd,
  output logic [7:0] rd_index,
  input wire logic [7:0] rd_byte,
  // status and control
  output logic fault_clear,
  output logic write_locked,
  output logic [7:0] interface_config_one
);

  import pmbus_slave_pkg::*;

  function automatic logic own_register(input logic [7:0] code);
    own_register = (code == CMD_INTERFACE_CONFIG_ONE) ||
                   (code == CMD_WRITE_LOCK_AND_RESET);
  endfunction

  function automatic logic protected_cmd(input logic [7:0] code);
    protected_cmd = (code >= PROTECTED_CMD_LOW) && (code <= PROTECTED_CMD_HIGH) &&
                    (code != CMD_WRITE_LOCK_AND_RESET);
  endfunction

  // crossing from the bus domain and the pins
  logic sampled_bit;
  logic bit_toggle;
  logic tog_meta, tog_sync, tog_prev;
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;

  pmbus_bit_sampler sampler
  (
    .scl_clk(scl_clk),
    .reset(reset),
    .sda_in(sda_in),
    .sampled_bit(sampled_bit),
    .bit_toggle(bit_toggle)
  );

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      tog_meta <= bit_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  logic bit_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic activity;

  assign bit_rise = tog_sync ^ tog_prev;
  assign scl_fall = scl_prev & ~scl_sync;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_cond = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign activity = bit_rise | scl_fall | start_cond | stop_cond;

  // protocol state
  slave_state_type state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_shift, next_rx_shift;
  logic reading, next_reading;
  logic [7:0] cmd, next_cmd;
  logic cmd_valid, next_cmd_valid;
  logic [7:0] byte_index, next_byte_index;
  logic [IDLE_COUNT_WIDTH-1:0] idle_cnt, next_idle_cnt;
  logic next_sda_oe_n;
  logic next_wr_strobe;
  logic [7:0] next_wr_cmd, next_wr_index, next_wr_byte;
  logic [7:0] next_rd_cmd, next_rd_index;
  logic next_fault_clear;
  logic next_write_locked;
  logic [7:0] next_interface_config_one;

  logic [7:0] full_byte;
  logic [7:0] tx_byte;

  assign full_byte = {rx_shift[6:0], sampled_bit};

  // own registers answer only at index 0; others come from the device
  always_comb
  begin
    tx_byte = rd_byte;
    if (own_register(rd_cmd))
    begin
      tx_byte = 8'h00;
      if (rd_index == 8'h00)
      begin
        if (rd_cmd == CMD_INTERFACE_CONFIG_ONE)
          tx_byte = interface_config_one;
        else
          tx_byte = {7'h00, write_locked};
      end
    end
  end

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_reading = reading;
    next_cmd = cmd;
    next_cmd_valid = cmd_valid;
    next_byte_index = byte_index;
    next_idle_cnt = '0;
    next_sda_oe_n = sda_oe_n;
    next_wr_strobe = 1'b0;
    next_wr_cmd = wr_cmd;
    next_wr_index = wr_index;
    next_wr_byte = wr_byte;
    next_rd_cmd = rd_cmd;
    next_rd_index = rd_index;
    next_fault_clear = 1'b0;
    next_write_locked = write_locked;
    next_interface_config_one = interface_config_one;

    if (interface_config_one[IDLE_RELEASE_ENABLE_BIT] && state != ST_IDLE && !activity) // R8
      next_idle_cnt = idle_cnt + 1'b1;

    if (interface_config_one[IDLE_RELEASE_ENABLE_BIT] && state != ST_IDLE &&
        idle_cnt == IDLE_COUNT_WIDTH'(IDLE_RELEASE_LIMIT - 1)) // R7
    begin
      // nothing but a new start wakes it again
      next_state = ST_IDLE; // R13
      next_sda_oe_n = 1'b1; // R7
      next_cmd_valid = 1'b0;
      next_idle_cnt = '0;
    end
    else if (stop_cond)
    begin
      // the clock rise that carries the stop has already counted one bit
      if (state == ST_RX && !reading && cmd_valid && bit_cnt <= 4'h1 &&
          byte_index == 8'h00)
        next_fault_clear = 1'b1; // R12
      next_state = ST_IDLE;
      next_sda_oe_n = 1'b1;
      next_cmd_valid = 1'b0;
    end
    else if (start_cond)
    begin
      // command survives a repeated start for the read phase
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe_n = 1'b1;
    end
    else if (bit_rise)
    begin
      case (state)
        ST_ADDR:
        begin
          next_rx_shift = full_byte;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h7)
          begin
            next_bit_cnt = 4'h0;
            // a read with no command in this transaction is refused
            if (full_byte[7:1] == SLAVE_ADDRESS && (!full_byte[0] || cmd_valid)) // R11
            begin
              next_state = ST_ADDR_ACK;
              next_reading = full_byte[0];
            end
            else
              next_state = ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          next_bit_cnt = 4'h0;
          next_byte_index = 8'h00;
          if (reading)
          begin
            next_state = ST_TX; // R4
            next_rd_cmd = cmd;
            next_rd_index = 8'h00;
          end
          else
          begin
            next_state = ST_RX;
            next_cmd_valid = 1'b0;
          end
        end
        ST_RX:
        begin
          next_rx_shift = full_byte;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h7)
          begin
            next_bit_cnt = 4'h0;
            next_state = ST_RX_ACK; // R3
            if (!cmd_valid)
            begin
              next_cmd = full_byte;
              next_cmd_valid = 1'b1;
            end
            else
            begin
              next_byte_index = byte_index + 8'h01;
              if (!(write_locked && protected_cmd(cmd))) // R10
              begin
                next_wr_strobe = 1'b1; // R1
                next_wr_cmd = cmd;
                next_wr_index = byte_index; // R2
                next_wr_byte = full_byte;
                if (byte_index == 8'h00 && cmd == CMD_INTERFACE_CONFIG_ONE)
                  next_interface_config_one = full_byte; // R8
                if (byte_index == 8'h00 && cmd == CMD_WRITE_LOCK_AND_RESET &&
                    full_byte[LOCK_SET_BIT])
                  next_write_locked = 1'b1; // R9
              end
            end
          end
        end
        ST_RX_ACK:
        begin
          next_state = ST_RX;
          next_bit_cnt = 4'h0;
        end
        ST_TX:
        begin
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h7)
          begin
            next_bit_cnt = 4'h0;
            next_state = ST_TX_ACK;
          end
        end
        ST_TX_ACK:
        begin
          // master ack asks for the next byte, no-ack ends the read
          if (!sampled_bit)
          begin
            next_state = ST_TX; // R5 R6
            next_byte_index = byte_index + 8'h01;
            next_rd_index = byte_index + 8'h01;
          end
          else
            next_state = ST_IDLE;
        end
        default:
          next_state = ST_IDLE;
      endcase
    end
    else if (scl_fall)
    begin
      // data changes only while the clock is low
      case (state)
        ST_ADDR_ACK, ST_RX_ACK:
          next_sda_oe_n = 1'b0; // R3
        ST_TX:
          next_sda_oe_n = tx_byte[3'd7 - bit_cnt[2:0]]; // R5 R6
        default:
          next_sda_oe_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      reading <= 1'b0;
      cmd <= 8'h00;
      cmd_valid <= 1'b0;
      byte_index <= 8'h00;
      idle_cnt <= '0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_strobe <= 1'b0;
      wr_cmd <= 8'h00;
      wr_index <= 8'h00;
      wr_byte <= 8'h00;
      rd_cmd <= 8'h00;
      rd_index <= 8'h00;
      fault_clear <= 1'b0;
      write_locked <= LOCK_FLAG_RESET; // R10
      interface_config_one <= INTERFACE_CONFIG_ONE_RESET; // R8
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      reading <= next_reading;
      cmd <= next_cmd;
      cmd_valid <= next_cmd_valid;
      byte_index <= next_byte_index;
      idle_cnt <= next_idle_cnt;
      sda_out <= 1'b0;
      sda_oe_n <= next_sda_oe_n;
      wr_strobe <= next_wr_strobe;
      wr_cmd <= next_wr_cmd;
      wr_index <= next_wr_index;
      wr_byte <= next_wr_byte;
      rd_cmd <= next_rd_cmd;
      rd_index <= next_rd_index;
      fault_clear <= next_fault_clear;
      write_locked <= next_write_locked;
      interface_config_one <= next_interface_config_one;
    end
  end

endmodule
`default_nettype wire

// ### sim/pmbus_engine_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pmbus_engine_monitor
  import pmbus_slave_pkg::*;
#(
  parameter int IDLE_RELEASE_LIMIT = 200
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // register side
  input wire logic wr_strobe,
  input wire logic [7:0] wr_cmd,
  input wire logic fault_clear,
  input wire logic write_locked,
  input wire logic [7:0] interface_config_one
);
  logic [31:0] quiet;
  logic [31:0] next_quiet;
  logic scl_q;
  logic sda_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_pulse(x);
    x ##1 !x;
  endsequence
  // any wire edge restarts the quiet count
  always_comb
  begin
    next_quiet = quiet + 32'h1;
    if (scl_in != scl_q || sda_in != sda_q)
      next_quiet = 32'h0;
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      quiet <= 32'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      quiet <= next_quiet;
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end
  a_sda_low_only: assert property (sda_out == 1'b0) else $error("sda data not low");
  a_pull_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in) else $error("pull in scl high");
  a_strobe_pulse: assert property (wr_strobe |-> s_pulse(wr_strobe)) else $error("strobe long");
  a_clear_pulse: assert property (fault_clear |-> s_pulse(fault_clear)) else $error("clear long");
  a_lock_sticky: assert property (write_locked |=> write_locked) else $error("lock dropped");
  a_config_frozen: assert property (write_locked |=> $stable(interface_config_one))
    else $error("config changed while locked");
  a_locked_skip: assert property (write_locked && wr_strobe |-> wr_cmd == CMD_WRITE_LOCK_AND_RESET
    || wr_cmd < PROTECTED_CMD_LOW || wr_cmd > PROTECTED_CMD_HIGH) else $error("locked write");
  a_reset_values: assert property ($fell(reset) |-> interface_config_one ==
    INTERFACE_CONFIG_ONE_RESET && write_locked == LOCK_FLAG_RESET) else $error("reset value");
  a_idle_release: assert property (interface_config_one[IDLE_RELEASE_ENABLE_BIT]
    && quiet > IDLE_RELEASE_LIMIT + 8 |-> sda_oe_n) else $error("bus held after idle");
endmodule
bind pmbus_slave_protocol_engine pmbus_engine_monitor #(.IDLE_RELEASE_LIMIT(IDLE_RELEASE_LIMIT))
  i_mon (.core_clk, .reset, .scl_in, .sda_in, .sda_out, .sda_oe_n, .wr_strobe, .wr_cmd,
  .fault_clear, .write_locked, .interface_config_one);
`default_nettype wire

// ### sim/pmbus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmbus_master_model
(
  // bus wires
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // scl rests high between frames
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // data moves only in the low phase
  task automatic pulse(input logic v, output logic s);
    scl = 1'b0;
    #8.3 sda_rel = v;
    #23.7 scl = 1'b1;
    s = sda;
    #32;
  endtask
  // start, repeated start or stop: sda moves while scl high
  task automatic cond(input logic a, input logic b);
    scl = 1'b0;
    #9.1 sda_rel = a;
    #22.9 scl = 1'b1;
    #16 sda_rel = b;
    #16;
  endtask
  task automatic bits(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(d[i], s);
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic s;
    bits(d);
    pulse(1'b1, s);
    ack = !s;
  endtask
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(1'b1, d[i]);
    pulse(last, s);
  endtask
  task automatic park;
    scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/pmbus_slave_protocol_engine_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pmbus_slave_protocol_engine_bench;
  import pmbus_slave_pkg::*;
  typedef struct {logic rd; logic [7:0] cmd; logic [7:0] d; int n;} row_type;
  localparam int LIMIT = 200;
  localparam logic [7:0] ADDR_W = {SLAVE_ADDRESS_DEFAULT, 1'b0};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] rd_byte = 8'h00;
  logic scl, sda_rel, a, sda_out, sda_oe_n, wr_strobe, fault_clear, write_locked;
  logic [7:0] wr_cmd, wr_index, wr_byte, rd_cmd, rd_index, interface_config_one;
  wire logic sda;
  int err_count = 0;
  int n_tests = 0;
  int fc_cnt = 0;
  logic [23:0] seen[$];
  row_type rows [6] = '{
    '{1'b0, 8'h21, 8'hA5, 2},
    '{1'b0, 8'h30, 8'h03, 4},
    '{1'b0, 8'h03, 8'h00, 0},
    '{1'b1, 8'h21, 8'h00, 1},
    '{1'b1, 8'h40, 8'h00, 2},
    '{1'b1, 8'h50, 8'h00, 4}
  };
  // wired and with the pull-up
  assign sda = sda_rel & sda_oe_n;
  always #2 core_clk = ~core_clk;
  always @(negedge core_clk) rd_byte <= rd_cmd ^ rd_index;
  always @(posedge core_clk)
  begin
    if (wr_strobe)
      seen.push_back({wr_cmd, wr_index, wr_byte});
    if (fault_clear)
      fc_cnt++;
  end
  pmbus_slave_protocol_engine #(.IDLE_RELEASE_LIMIT(LIMIT)) i_dut (.core_clk, .reset,
    .scl_clk(scl), .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n, .wr_strobe, .wr_cmd,
    .wr_index, .wr_byte, .rd_cmd, .rd_index, .rd_byte, .fault_clear, .write_locked,
    .interface_config_one);
  pmbus_master_model i_master (.scl, .sda_rel, .sda);
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_write(input logic [7:0] cmd, input logic [7:0] d, input int n,
    input logic ok);
    int f0;
    f0 = fc_cnt;
    seen.delete();
    i_master.cond(1'b1, 1'b0);
    i_master.byte_tx(ADDR_W, a);
    check(a, 1'b1);
    i_master.byte_tx(cmd, a);
    check(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_master.byte_tx(d + 8'(i), a);
      check(a, 1'b1);
    end
    i_master.cond(1'b0, 1'b1);
    repeat (8) @(negedge core_clk);
    check(seen.size(), ok ? n : 0);
    for (int i = 0; i < seen.size(); i++)
      check(seen[i], {cmd, 8'(i), d + 8'(i)});
    check(fc_cnt - f0, n == 0);
  endtask
  task automatic do_read(input logic [7:0] cmd, input int n);
    logic [7:0] b;
    i_master.cond(1'b1, 1'b0);
    i_master.byte_tx(ADDR_W, a);
    i_master.byte_tx(cmd, a);
    i_master.cond(1'b1, 1'b0);
    i_master.byte_tx(ADDR_W | 8'h01, a);
    check(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_master.byte_rx(i == n - 1, b);
      check(b, cmd ^ 8'(i));
    end
    i_master.cond(1'b0, 1'b1);
  endtask
  initial
  begin
    #300000;
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    check(interface_config_one, INTERFACE_CONFIG_ONE_RESET);
    check(write_locked, LOCK_FLAG_RESET);
    foreach (rows[k])
    begin
      if (rows[k].rd)
        do_read(rows[k].cmd, rows[k].n);
      else
        do_write(rows[k].cmd, rows[k].d, rows[k].n, 1'b1);
    end
    i_master.cond(1'b1, 1'b0);
    i_master.byte_tx(ADDR_W ^ 8'h02, a);
    check(a, 1'b0);
    i_master.cond(1'b0, 1'b1);
    // a read with no command since the last stop is refused
    i_master.cond(1'b1, 1'b0);
    i_master.byte_tx(ADDR_W | 8'h01, a);
    check(a, 1'b0);
    i_master.cond(1'b0, 1'b1);
    do_write(CMD_INTERFACE_CONFIG_ONE, 8'h08, 1, 1'b1);
    check(interface_config_one, 8'h08);
    // stall inside the ack slot so the engine holds sda
    i_master.cond(1'b1, 1'b0);
    i_master.bits(ADDR_W);
    i_master.park();
    #20 check(sda_oe_n, 1'b0);
    repeat (LIMIT + 60) @(negedge core_clk);
    check(sda_oe_n, 1'b1);
    i_master.pulse(1'b1, a);
    i_master.byte_tx(ADDR_W, a);
    check(a, 1'b0);
    i_master.cond(1'b0, 1'b1);
    do_write(CMD_WRITE_LOCK_AND_RESET, 8'h01, 1, 1'b1);
    check(write_locked, 1'b1);
    do_write(CMD_INTERFACE_CONFIG_ONE, 8'h00, 1, 1'b0);
    do_write(CMD_WRITE_LOCK_AND_RESET, 8'h00, 1, 1'b1);
    check(write_locked, 1'b1);
    check(interface_config_one, 8'h08);
    reset = 1'b1;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    check(write_locked, 1'b0);
    do_write(8'hD5, 8'h5A, 2, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
